// ---- rtl/dse_pkg.sv ----
/*
 * dse_pkg: register map, field positions, reset values, state types and
 * carrier structs for the dma status and endpoint select block.
 * assumes a single 200 MHz clock domain and an APB register bus.
 */
package dse_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;

	localparam logic [11:0] CAUSE_OFS = 12'h250;
	localparam logic [11:0] MASK_OFS = 12'h254;
	localparam logic [11:0] ROUTE_OFS = 12'h258;
	localparam logic [11:0] SUMMARY_OFS = 12'h218;

	localparam int unsigned STOP_BIT = 12;
	localparam int unsigned SHORT_END_BIT = 10;
	localparam int unsigned COUNT_DONE_BIT = 8;
	localparam int unsigned SUMMARY_DMA_BIT = 6;

	localparam logic [15:0] CAUSE_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic [15:0] EVENT_BITS = 16'h1500;
	localparam logic [7:0] ROUTE_BITS = 8'h0F;

	localparam int unsigned EP_SEL_W = 3;
	localparam int unsigned EP_SEL_LSB = 1;
	localparam int unsigned DIR_BIT = 0;

	localparam logic [31:0] ERR_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_ACCESS = 2'b01
	} dse_apb_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [3:0] pstrb;
	} dse_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} dse_apb_rsp_type;

	typedef struct packed {
		logic stop_cmd;
		logic short_packet_end;
		logic counter_zero;
	} dse_event_type;

	typedef struct packed {
		logic [EP_SEL_W-1:0] dma_endpoint_select;
		logic dma_fifo_direction;
	} dse_route_type;

endpackage : dse_pkg

// ---- rtl/dse_apb_slave.sv ----
/*
 * dse_apb_slave: apb decode front end; turns a completed apb access into
 * one-cycle read/write strobes qualified by the address hit.
 * assumes a well-behaved apb master; answers with zero wait states.
 */
`timescale 1ns/1ps
module dse_apb_slave (
	input wire logic sys_clk,
	input wire logic arst_n,
	input dse_pkg::dse_apb_req_type req,
	output dse_pkg::dse_apb_rsp_type rsp,
	output logic wr_stb,
	output logic rd_stb,
	input wire logic [31:0] rd_data,
	input wire logic addr_hit
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pslverr;
	} dse_slv_state_type;

	dse_slv_state_type s_q;
	dse_slv_state_type s_d;
	logic access;

	// single-cycle access phase keeps read side effects to one strobe
	assign access = req.psel && req.penable;
	assign wr_stb = access && req.pwrite && addr_hit;
	assign rd_stb = access && !req.pwrite && addr_hit;

	always_comb begin
		s_d = s_q;
		if (req.psel && !req.penable) begin
			s_d.pslverr = !addr_hit;
			s_d.prdata = addr_hit ? rd_data : dse_pkg::ERR_DATA;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp.pready = 1'b1;
	assign rsp.pslverr = access && s_q.pslverr;
	assign rsp.prdata = access ? s_q.prdata : dse_pkg::ERR_DATA;
endmodule : dse_apb_slave

// ---- rtl/dse_irq_gate.sv ----
/*
 * dse_irq_gate: masks the cause flags and forms the level interrupt.
 * assumes cause and mask share one layout.
 */
`timescale 1ns/1ps
module dse_irq_gate (
	input wire logic [15:0] cause,
	input wire logic [15:0] mask,
	input wire logic summary_dma,
	output logic dma_pending,
	output logic irq
);
	assign dma_pending = |(cause & mask & dse_pkg::EVENT_BITS);
	assign irq = summary_dma;
endmodule : dse_irq_gate

// ---- rtl/dse_top.sv ----
/*
 * dse_top: dma event cause flags, their interrupt enables, the dma
 * endpoint route and the dma bit of the device interrupt summary.
 * assumes event pulses come from the dma engine synchronous to sys_clk,
 * one cycle each, raised when a dma command completes.
 */
// Function
// - refresh cause flags when dma command finishes
// - writing one clears flag, zero keeps
// - stop command sets cause bit 12
// - counter zero sets cause bit 8
// - short packet end sets bit 10
// - short packet early: bit10 only
// - short packet at zero: both bits
// - zero without short packet: bit8 only
// - enable bits gate matching cause flags
// - enables read zero after any reset
// - bits 3 to 1 pick endpoint
// - bit 0 picks fifo direction
// - interrupt line high while summary nonzero
`timescale 1ns/1ps
module dse_top (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic bus_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic evt_stop_cmd,
	input wire logic evt_short_packet_end,
	input wire logic evt_counter_zero,
	output logic [2:0] dma_endpoint_select,
	output logic dma_fifo_direction,
	output logic irq
);
	typedef struct packed {
		logic [15:0] cause;
		logic [15:0] mask;
		logic [7:0] route;
		logic summary_dma;
	} dse_state_type;

	dse_state_type st_q;
	dse_state_type st_d;
	dse_pkg::dse_apb_req_type req;
	dse_pkg::dse_apb_rsp_type rsp;
	dse_pkg::dse_event_type evt;
	logic wr_stb;
	logic rd_stb;
	logic addr_hit;
	logic [31:0] rd_data;
	logic dma_pending;
	logic [15:0] set_vec;
	logic [15:0] wr_lo;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
		pwdata: pwdata, pstrb: pstrb};
	assign evt = '{stop_cmd: evt_stop_cmd, short_packet_end: evt_short_packet_end,
		counter_zero: evt_counter_zero};

	dse_apb_slave u_slave (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.req(req),
		.rsp(rsp),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rd_data(rd_data),
		.addr_hit(addr_hit)
	);

	dse_irq_gate u_gate (
		.cause(st_q.cause),
		.mask(st_q.mask),
		.summary_dma(st_q.summary_dma),
		.dma_pending(dma_pending),
		.irq(irq)
	);

	assign addr_hit = (paddr == dse_pkg::CAUSE_OFS) || (paddr == dse_pkg::MASK_OFS) ||
		(paddr == dse_pkg::ROUTE_OFS) || (paddr == dse_pkg::SUMMARY_OFS);

	// byte lanes 0 and 1 carry the 16-bit registers
	always_comb begin
		wr_lo = 16'h0000;
		if (pstrb[0]) begin
			wr_lo[7:0] = pwdata[7:0];
		end
		if (pstrb[1]) begin
			wr_lo[15:8] = pwdata[15:8];
		end
	end

	// each completion event drives its own flag; simultaneous events set both
	always_comb begin
		set_vec = 16'h0000;
		set_vec[dse_pkg::STOP_BIT] = evt.stop_cmd;
		set_vec[dse_pkg::SHORT_END_BIT] = evt.short_packet_end;
		set_vec[dse_pkg::COUNT_DONE_BIT] = evt.counter_zero;
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr)
			dse_pkg::CAUSE_OFS: rd_data = {16'h0000, st_q.cause};
			dse_pkg::MASK_OFS: rd_data = {16'h0000, st_q.mask};
			dse_pkg::ROUTE_OFS: rd_data = {24'h00_0000, st_q.route};
			dse_pkg::SUMMARY_OFS: rd_data = {25'h000_0000, st_q.summary_dma, 6'h00};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_comb begin
		st_d = st_q;
		// write-one-to-clear; a same-cycle event wins over the clear
		if (wr_stb && paddr == dse_pkg::CAUSE_OFS) begin
			st_d.cause = st_q.cause & ~wr_lo;
		end
		st_d.cause = (st_d.cause | set_vec) & dse_pkg::EVENT_BITS;
		if (wr_stb && paddr == dse_pkg::MASK_OFS) begin
			st_d.mask = wr_lo & dse_pkg::EVENT_BITS;
		end
		if (wr_stb && paddr == dse_pkg::ROUTE_OFS && pstrb[0]) begin
			st_d.route = pwdata[7:0] & dse_pkg::ROUTE_BITS;
		end
		// summary bit stays up until software writes one while no cause pends
		if (wr_stb && paddr == dse_pkg::SUMMARY_OFS && pstrb[0] &&
			pwdata[dse_pkg::SUMMARY_DMA_BIT]) begin
			st_d.summary_dma = 1'b0;
		end
		if (dma_pending) begin
			st_d.summary_dma = 1'b1;
		end
		if (bus_reset) begin
			st_d.cause = dse_pkg::CAUSE_RESET;
			st_d.mask = dse_pkg::MASK_RESET;
			st_d.route = dse_pkg::ROUTE_RESET;
			st_d.summary_dma = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '{cause: dse_pkg::CAUSE_RESET, mask: dse_pkg::MASK_RESET,
				route: dse_pkg::ROUTE_RESET, summary_dma: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign dma_endpoint_select = st_q.route[dse_pkg::EP_SEL_LSB +: dse_pkg::EP_SEL_W];
	assign dma_fifo_direction = st_q.route[dse_pkg::DIR_BIT];
	assign pready = rsp.pready;
	assign pslverr = rsp.pslverr;
	assign prdata = rsp.prdata;

	logic unused_rd;
	assign unused_rd = rd_stb;

	sequence stop_seen_s;
		evt_stop_cmd && !bus_reset;
	endsequence

	stop_sets_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		stop_seen_s |=> st_q.cause[12])
		else $error("stop event did not set bit 12");
	short_sets_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		evt_short_packet_end && !bus_reset |=> st_q.cause[10])
		else $error("short end event did not set bit 10");
	zero_sets_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		evt_counter_zero && !bus_reset |=> st_q.cause[8])
		else $error("count done event did not set bit 8");
	only_short_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		evt_short_packet_end && !evt_counter_zero && !st_q.cause[8] |=> !st_q.cause[8])
		else $error("short end wrongly set count done");
	only_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		evt_counter_zero && !evt_short_packet_end && !st_q.cause[10] |=> !st_q.cause[10])
		else $error("count done wrongly set short end");
	w1c_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_stb && paddr == 12'h250 && pstrb[1] && pwdata[12] && !evt_stop_cmd
		|=> !st_q.cause[12])
		else $error("write one did not clear stop flag");
	w0_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_stb && paddr == 12'h250 && !pwdata[8] && st_q.cause[8] && !bus_reset
		|=> st_q.cause[8])
		else $error("write zero changed count done flag");
	mask_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!st_q.summary_dma && (st_q.cause & st_q.mask) == 16'h0000 |=> !st_q.summary_dma)
		else $error("summary raised without enabled cause");
	summary_up_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q.cause & st_q.mask) != 16'h0000 && !bus_reset |=> st_q.summary_dma)
		else $error("enabled cause did not hold summary");
	irq_level_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		irq == st_q.summary_dma)
		else $error("irq differs from summary");
	bus_rst_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		bus_reset |=> st_q.mask == 16'h0000 && dma_endpoint_select == 3'h0)
		else $error("bus reset left enables set");
	route_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_stb && paddr == 12'h258 && pstrb[0] && !bus_reset
		|=> dma_endpoint_select == $past(pwdata[3:1]) && dma_fifo_direction == $past(pwdata[0]))
		else $error("route write not reflected");

	// an enable write keeps only bits 12, 10 and 8 of pwdata, one cycle later
	sequence mask_wr_s;
		wr_stb && paddr == dse_pkg::MASK_OFS && pstrb[1] && !bus_reset;
	endsequence
	mask_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mask_wr_s
		|=> st_q.mask == ($past(pwdata[15:0]) & 16'h1500))
		else $error("enable write not stored");

	sequence mask_idle_s;
		!(wr_stb && paddr == dse_pkg::MASK_OFS) && !bus_reset;
	endsequence
	mask_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mask_idle_s
		|=> $stable(st_q.mask))
		else $error("enables changed without a write");

	sequence summary_rise_s;
		!st_q.summary_dma ##1 st_q.summary_dma;
	endsequence
	summary_cause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		summary_rise_s
		|-> $past(dma_pending))
		else $error("summary rose without enabled cause");

	sequence cause_idle_s;
		!(wr_stb && paddr == dse_pkg::CAUSE_OFS) && !bus_reset;
	endsequence
	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cause_idle_s and st_q.cause[12]
		|=> st_q.cause[12])
		else $error("stop flag dropped without a write");

	sequence cause_read_s;
		rd_stb && paddr == dse_pkg::CAUSE_OFS && !bus_reset;
	endsequence
	read_keeps_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cause_read_s and st_q.cause[8]
		|=> st_q.cause[8])
		else $error("reading cause cleared a flag");

	sequence both_evt_s;
		evt_short_packet_end && evt_counter_zero && !bus_reset;
	endsequence
	both_sets_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		both_evt_s
		|=> st_q.cause[10] && st_q.cause[8])
		else $error("short end at zero did not set both flags");

	sequence clr_short_s;
		wr_stb && paddr == dse_pkg::CAUSE_OFS && pstrb[1] && pwdata[10];
	endsequence
	w1c_short_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clr_short_s and !evt_short_packet_end
		|=> !st_q.cause[10])
		else $error("write one did not clear short end flag");

	sequence clr_zero_s;
		wr_stb && paddr == dse_pkg::CAUSE_OFS && pstrb[1] && pwdata[8];
	endsequence
	w1c_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clr_zero_s and !evt_counter_zero
		|=> !st_q.cause[8])
		else $error("write one did not clear count done flag");

	sequence keep_stop_s;
		wr_stb && paddr == dse_pkg::CAUSE_OFS && !pwdata[12] && !bus_reset;
	endsequence
	w0_stop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		keep_stop_s and st_q.cause[12]
		|=> st_q.cause[12])
		else $error("write zero changed stop flag");

	sequence bus_rst_s;
		bus_reset;
	endsequence
	bus_rst_cause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		bus_rst_s
		|=> st_q.cause == 16'h0000 && !st_q.summary_dma && !dma_fifo_direction)
		else $error("bus reset left flags set");

	sequence route_idle_s;
		!(wr_stb && paddr == dse_pkg::ROUTE_OFS) && !bus_reset;
	endsequence
	route_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		route_idle_s
		|=> $stable(dma_endpoint_select) && $stable(dma_fifo_direction))
		else $error("route changed without a write");

	sequence route_any_s;
		1'b1;
	endsequence
	route_rsvd_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		route_any_s
		|-> st_q.route[7:4] == 4'h0 && (st_q.cause & 16'hEAFF) == 16'h0000)
		else $error("reserved bits became set");

	sequence sum_clr_s;
		wr_stb && paddr == dse_pkg::SUMMARY_OFS && pstrb[0] && pwdata[6];
	endsequence
	irq_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sum_clr_s and !dma_pending
		|=> !irq)
		else $error("irq stayed up after summary clear");

	sequence sum_idle_s;
		!(wr_stb && paddr == dse_pkg::SUMMARY_OFS) && !bus_reset;
	endsequence
	summary_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sum_idle_s and st_q.summary_dma
		|=> st_q.summary_dma)
		else $error("summary dropped without a write");

	sequence unmapped_s;
		psel && penable && !addr_hit;
	endsequence
	err_resp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		unmapped_s
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	sequence mapped_s;
		psel && penable && addr_hit;
	endsequence
	ok_resp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mapped_s
		|-> !pslverr && pready)
		else $error("mapped access flagged as error");
endmodule : dse_top

// ---- sim/dse_evt_model.sv ----
/* dse_evt_model: stand-in for the dma engine that reports finished commands.
 assumes fire is held for one cycle by the bench, driven after a rising edge. */
`timescale 1ns/1ps
module dse_evt_model (
	input wire logic fire,
	input wire logic [2:0] kind,
	output logic evt_stop_cmd,
	output logic evt_short_packet_end,
	output logic evt_counter_zero
);
	// one pulse per finished command; kind is {stop, short end, count zero}
	assign evt_stop_cmd = fire & kind[2];
	assign evt_short_packet_end = fire & kind[1];
	assign evt_counter_zero = fire & kind[0];
endmodule : dse_evt_model

// ---- sim/dse_top_tb.sv ----
/* dse_top_tb: self-checking bench for dse_top over apb and event pulses.
 assumes zero or more wait states; every wait is bounded. */
`timescale 1ns/1ps
module dse_top_tb;
	typedef struct {
		logic [2:0] kind;
		logic [15:0] mask;
		logic [15:0] cause;
		logic irq;
	} dse_row_type;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic bus_reset = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic fire = 1'b0;
	logic [2:0] kind = 3'h0;
	logic pready, pslverr, irq, dma_fifo_direction, err;
	logic evt_stop_cmd, evt_short_packet_end, evt_counter_zero;
	logic [2:0] dma_endpoint_select;
	logic [31:0] prdata, rd;
	int error_cnt = 0;
	int samples_checked = 0;
	// stop, short end only, short end at zero, zero only, zero masked out
	dse_row_type rows [5] = '{'{3'h4, 16'h1000, 16'h1000, 1'b1},
		'{3'h2, 16'h0000, 16'h0400, 1'b0}, '{3'h3, 16'h0100, 16'h0500, 1'b1},
		'{3'h1, 16'h0100, 16'h0100, 1'b1}, '{3'h1, 16'h1400, 16'h0100, 1'b0}};
	logic [7:0] routes [2] = '{8'h0B, 8'h04};

	dse_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_reset(bus_reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .evt_stop_cmd(evt_stop_cmd),
		.evt_short_packet_end(evt_short_packet_end), .evt_counter_zero(evt_counter_zero),
		.dma_endpoint_select(dma_endpoint_select),
		.dma_fifo_direction(dma_fifo_direction), .irq(irq));
	dse_evt_model engine (.fire(fire), .kind(kind), .evt_stop_cmd(evt_stop_cmd),
		.evt_short_packet_end(evt_short_packet_end), .evt_counter_zero(evt_counter_zero));

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	// entered just after a rising edge; leaves one idle edge after release
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			rdy = pready;
		end while (rdy !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (rdy !== 1'b1) begin
			error_cnt++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic pulse(input logic [2:0] k);
		fire <= 1'b1;
		kind <= k;
		@(posedge sys_clk);
		fire <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : pulse

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, 12'h250, 32'h0);
		chk("cause_reset", rd, 32'h0);
		chk("mapped_err", {31'h0, err}, 32'h0);
		apb(1'b0, 12'h254, 32'h0);
		chk("mask_reset", rd, 32'h0);
		$display("test reset values done");
		foreach (rows[i]) begin
			apb(1'b1, 12'h254, {16'h0000, rows[i].mask});
			pulse(rows[i].kind);
			apb(1'b0, 12'h250, 32'h0);
			chk("cause", rd, {16'h0000, rows[i].cause});
			chk("irq", {31'h0, irq}, {31'h0, rows[i].irq});
			chk("enabled_source", {31'h0, |(rd[15:0] & rows[i].mask)}, {31'h0, rows[i].irq});
			apb(1'b1, 12'h250, 32'h0000_1500);
			apb(1'b1, 12'h218, 32'h0000_0040);
			chk("irq_cleared", {31'h0, irq}, 32'h0);
		end
		$display("test event rows done");
		pulse(3'h1);
		apb(1'b1, 12'h250, 32'h0);
		apb(1'b0, 12'h250, 32'h0);
		chk("zero_write_keeps", rd, 32'h0000_0100);
		apb(1'b1, 12'h250, 32'h0000_0100);
		apb(1'b0, 12'h250, 32'h0);
		chk("one_write_clears", rd, 32'h0);
		$display("test clear by one done");
		foreach (routes[i]) begin
			apb(1'b1, 12'h258, {24'h0, routes[i]});
			chk("route_pins", {28'h0, dma_endpoint_select, dma_fifo_direction},
				{28'h0, routes[i][3:0]});
			apb(1'b0, 12'h258, 32'h0);
			chk("route_read", rd, {24'h0, routes[i]});
		end
		$display("test route done");
		apb(1'b0, 12'h25C, 32'h0);
		chk("unmapped_err", {31'h0, err}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		$display("test unmapped done");
		apb(1'b1, 12'h254, 32'h0000_1500);
		bus_reset <= 1'b1;
		@(posedge sys_clk);
		bus_reset <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, 12'h254, 32'h0);
		chk("mask_bus_reset", rd, 32'h0);
		chk("route_bus_reset", {28'h0, dma_endpoint_select, dma_fifo_direction}, 32'h0);
		$display("test bus reset done");
		conclude();
	end
endmodule : dse_top_tb
